/* iwh_pkg.sv */
// Constants shared by the interrupt, watchdog and halt controller
// Assumes a single 125 MHz core clock and core-side instruction strobes
package iwh_pkg;
	// Register offsets in data memory
	localparam logic [7:0] OFS_WDOG_PRESCALE = 8'h09;
	localparam logic [7:0] OFS_IRQ_CONTROL   = 8'h0b;
	localparam logic [7:0] OFS_STATUS        = 8'h0a;
	localparam logic [7:0] OFS_USB_EVENT     = 8'h1a;
	localparam logic [7:0] OFS_USB_FIFO_REQ  = 8'h1b;
	localparam logic [7:0] OFS_SYS_CLK_CFG   = 8'h1c;
	// Interrupt control field positions
	localparam int BIT_GIE  = 0;
	localparam int BIT_UIE  = 1;
	localparam int BIT_TIE  = 3;
	localparam int BIT_UPND = 4;
	localparam int BIT_TPND = 6;
	localparam logic [7:0] IRQ_CTRL_IMPL = 8'h5b;
	// USB event control field positions
	localparam int BIT_SUSPEND = 0;
	localparam int BIT_RESUME  = 3;
	localparam int BIT_BUS_RST = 2;
	// Status field positions
	localparam int BIT_PDF = 4;
	localparam int BIT_TO  = 5;
	// System clock config field position
	localparam int BIT_FREQ_SEL = 0;
	// Vectors
	localparam logic [7:0] VEC_USB   = 8'h04;
	localparam logic [7:0] VEC_TIMER = 8'h0c;
	// Reset values
	localparam logic [7:0] RST_WDOG_PRESCALE = 8'h87;
	localparam logic [7:0] RST_IRQ_CONTROL   = 8'h00;
	localparam logic [7:0] RST_SYS_CLK_CFG   = 8'h00;
	localparam logic [7:0] WDOG_USER_MASK    = 8'hf8;
	// Watchdog geometry
	localparam int WDOG_FIXED_STAGES = 8;
	localparam int WDOG_PRESC_STAGES = 7;
	localparam int INSTR_CLK_DIV     = 4;
	// Wake-up dummy delay in system clock periods
	localparam int WAKE_DELAY_CYCLES = 1024;
	// Halt sequencer states, Gray except from waking back to run
	typedef enum logic [1:0] {
		IWH_RUN    = 2'b00,
		IWH_HALTED = 2'b01,
		IWH_WAKING = 2'b11
	} iwh_halt_state_t;
endpackage

/* iwh_wdog_if.sv */
// Interface between the main controller and the watchdog counter
// Assumes both ends share ref_clk
`timescale 1ns/100ps
interface iwh_wdog_if;
	logic       clear;
	logic       tick;
	logic [2:0] ratio;
	logic       expire;
	modport ctrl (output clear, output tick, output ratio, input expire);
	modport cnt  (input clear, input tick, input ratio, output expire);
endinterface

/* iwh_wdog_cnt.sv */
// Watchdog counter: fixed 256 divider then 1:1..1:128 prescaler
// Assumes tick is a one-cycle watchdog clock event
`timescale 1ns/100ps
module iwh_wdog_cnt #(
	parameter int FIX_W = iwh_pkg::WDOG_FIXED_STAGES,
	parameter int PRE_W = iwh_pkg::WDOG_PRESC_STAGES
) (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	iwh_wdog_if.cnt   wd
);
	logic [FIX_W+PRE_W-1:0] cnt_q;
	logic                   term;

	// Terminal count after 256 times 2 to the ratio ticks
	always_comb begin
		term = (cnt_q[FIX_W-1:0] == '1) &&
			((cnt_q[FIX_W+PRE_W-1:FIX_W] & ((PRE_W'(1) << wd.ratio) - 1'b1))
			== ((PRE_W'(1) << wd.ratio) - 1'b1));
	end

	// Count and clear
	always_ff @(posedge ref_clk) begin
		if (!reset_n || wd.clear) begin
			cnt_q <= '0;
		end else if (wd.tick) begin
			cnt_q <= term ? '0 : cnt_q + 1'b1;
		end
	end

	// Expire pulse
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			wd.expire <= 1'b0;
		end else begin
			wd.expire <= wd.tick && term && !wd.clear;
		end
	end
endmodule

/* iwh_wake_timer.sv */
// Start-up delay timer inserted after a wake-up
// Assumes start is a one-cycle pulse
`timescale 1ns/100ps
module iwh_wake_timer #(
	parameter int CYCLES = iwh_pkg::WAKE_DELAY_CYCLES
) (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic start,
	output logic      done
);
	logic [$clog2(CYCLES+1)-1:0] cnt_q;

	// Count down the dummy period
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cnt_q <= '0;
			done  <= 1'b0;
		end else if (start) begin
			cnt_q <= ($clog2(CYCLES+1))'(CYCLES - 1);
			done  <= 1'b0;
		end else begin
			done  <= (cnt_q == 1);
			if (cnt_q != 0) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule

/* iwh_ctrl.sv */
// Interrupt, watchdog and power-down controller of the core
// Assumes synchronous core strobes and a single-cycle data memory port
`timescale 1ns/100ps
module iwh_ctrl #(
	parameter bit WDOG_ENABLE  = 1'b1,
	parameter bit WDOG_FROM_RC = 1'b1,
	parameter bit WDOG_PAIRED  = 1'b0,
	parameter int ENDPOINTS    = 2
) (
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic       ext_rst_pin,
	input  wire logic       mem_wr,
	input  wire logic       mem_rd,
	input  wire logic [7:0] mem_addr,
	input  wire logic [7:0] mem_wdata,
	output logic      [7:0] mem_rdata,
	input  wire logic       phase_two_pulse,
	input  wire logic       stack_full,
	input  wire logic       interrupt_exit,
	input  wire logic       subroutine_exit,
	input  wire logic       wdog_kick,
	input  wire logic       wdog_kick_first,
	input  wire logic       wdog_kick_second,
	input  wire logic       halt_exec,
	input  wire logic       rc_osc_tick,
	input  wire logic       timer_overflow,
	input  wire logic [1:0] host_fifo_access,
	input  wire logic       usb_suspend,
	input  wire logic       usb_resume,
	input  wire logic       usb_bus_reset,
	input  wire logic       port_wake,
	output logic            irq_call,
	output logic      [7:0] irq_vector,
	output logic            sys_osc_stop,
	output logic            core_stall,
	output logic            chip_reset,
	output logic            warm_reset
);
	iwh_pkg::iwh_halt_state_t st_q;
	logic [7:0]  irq_control_reg_q;
	logic [7:0]  wdog_prescale_reg_q;
	logic [7:0]  usb_fifo_request_reg_q;
	logic [7:0]  usb_event_ctrl_reg_q;
	logic [7:0]  sys_clock_cfg_reg_q;
	logic        wdog_expired_flag_q;
	logic        powerdown_flag_q;
	logic        kick1_seen_q;
	logic        kick2_seen_q;
	logic [1:0]  div4_q;
	logic        ack_pend_q;
	logic        usb_req;
	logic        tmr_req;
	logic        usb_go;
	logic        tmr_go;
	logic        take;
	logic        kick_clr;
	logic        wr_irq;
	logic        wr_status;
	logic        wake_ev;
	logic        wake_done;
	logic        halting;
	logic        usb_new;
	logic        pnd_usb_at_halt_q;
	logic        pnd_tmr_at_halt_q;
	iwh_wdog_if  wd ();

	// Write decode used for several registers
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return mem_wr && (a == o);
	endfunction

	assign wr_irq    = hit(mem_addr, iwh_pkg::OFS_IRQ_CONTROL);
	assign wr_status = hit(mem_addr, iwh_pkg::OFS_STATUS);
	assign halting   = halt_exec && (st_q == iwh_pkg::IWH_RUN);

	// USB sources all feed one request
	assign usb_new = (|host_fifo_access) || usb_suspend || usb_resume
		|| usb_bus_reset;

	// Service decision with fixed priority
	always_comb begin
		usb_req = irq_control_reg_q[iwh_pkg::BIT_UPND]
			&& irq_control_reg_q[iwh_pkg::BIT_UIE];
		tmr_req = irq_control_reg_q[iwh_pkg::BIT_TPND]
			&& irq_control_reg_q[iwh_pkg::BIT_TIE];
		take    = phase_two_pulse && !stack_full
			&& irq_control_reg_q[iwh_pkg::BIT_GIE]
			&& (st_q == iwh_pkg::IWH_RUN) && !ack_pend_q;
		usb_go  = take && usb_req;
		tmr_go  = take && tmr_req && !usb_req;
	end

	// Hold off service while a wake still waits out its delay
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			ack_pend_q <= 1'b0;
		end else begin
			ack_pend_q <= (st_q == iwh_pkg::IWH_WAKING) && !wake_done;
		end
	end

	// Interrupt control register; hardware set beats software clear
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			irq_control_reg_q <= iwh_pkg::RST_IRQ_CONTROL;
		end else begin
			if (wr_irq) begin
				irq_control_reg_q <= mem_wdata & iwh_pkg::IRQ_CTRL_IMPL;
			end
			if (usb_go) begin
				irq_control_reg_q[iwh_pkg::BIT_UPND] <= 1'b0;
				irq_control_reg_q[iwh_pkg::BIT_GIE]  <= 1'b0;
			end
			if (tmr_go) begin
				irq_control_reg_q[iwh_pkg::BIT_TPND] <= 1'b0;
				irq_control_reg_q[iwh_pkg::BIT_GIE]  <= 1'b0;
			end
			if (interrupt_exit) begin
				irq_control_reg_q[iwh_pkg::BIT_GIE] <= 1'b1;
			end
			if (usb_new) begin
				irq_control_reg_q[iwh_pkg::BIT_UPND] <= 1'b1;
			end
			if (timer_overflow) begin
				irq_control_reg_q[iwh_pkg::BIT_TPND] <= 1'b1;
			end
		end
	end

	// Interrupt call outputs
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			irq_call   <= 1'b0;
			irq_vector <= 8'h00;
		end else begin
			irq_call   <= usb_go || tmr_go;
			irq_vector <= usb_go ? iwh_pkg::VEC_USB :
				(tmr_go ? iwh_pkg::VEC_TIMER : irq_vector);
		end
	end

	// USB FIFO request and event registers; set wins over firmware clear
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			usb_fifo_request_reg_q <= 8'h00;
			usb_event_ctrl_reg_q   <= 8'h00;
		end else begin
			if (hit(mem_addr, iwh_pkg::OFS_USB_FIFO_REQ)) begin
				usb_fifo_request_reg_q <= mem_wdata;
			end
			if (hit(mem_addr, iwh_pkg::OFS_USB_EVENT)) begin
				usb_event_ctrl_reg_q <= mem_wdata;
			end
			for (int i = 0; i < ENDPOINTS; i++) begin
				if (host_fifo_access[i]) begin
					usb_fifo_request_reg_q[i] <= 1'b1;
				end
			end
			if (usb_suspend) begin
				usb_event_ctrl_reg_q[iwh_pkg::BIT_SUSPEND] <= 1'b1;
			end
			if (usb_resume) begin
				usb_event_ctrl_reg_q[iwh_pkg::BIT_RESUME] <= 1'b1;
			end
			if (usb_bus_reset) begin
				usb_event_ctrl_reg_q[iwh_pkg::BIT_BUS_RST] <= 1'b1;
			end
		end
	end

	// Clock configuration and watchdog prescale registers
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			sys_clock_cfg_reg_q <= iwh_pkg::RST_SYS_CLK_CFG;
			wdog_prescale_reg_q <= iwh_pkg::RST_WDOG_PRESCALE;
		end else begin
			if (hit(mem_addr, iwh_pkg::OFS_SYS_CLK_CFG)) begin
				sys_clock_cfg_reg_q <= mem_wdata;
			end
			if (hit(mem_addr, iwh_pkg::OFS_WDOG_PRESCALE)) begin
				wdog_prescale_reg_q <= mem_wdata;
			end
		end
	end

	// Kick handling, single or paired
	always_ff @(posedge ref_clk) begin
		if (!reset_n || kick_clr) begin
			kick1_seen_q <= 1'b0;
			kick2_seen_q <= 1'b0;
		end else begin
			if (wdog_kick_first) begin
				kick1_seen_q <= 1'b1;
			end
			if (wdog_kick_second) begin
				kick2_seen_q <= 1'b1;
			end
		end
	end

	// A kick counts only when the watchdog exists
	always_comb begin
		if (!WDOG_ENABLE) begin
			kick_clr = 1'b0;
		end else if (WDOG_PAIRED) begin
			kick_clr = (kick1_seen_q || wdog_kick_first)
				&& (kick2_seen_q || wdog_kick_second);
		end else begin
			kick_clr = wdog_kick;
		end
	end

	// Instruction clock is system clock over four
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			div4_q <= 2'b00;
		end else begin
			div4_q <= div4_q + 2'b01;
		end
	end

	// Watchdog clock source and clears
	always_comb begin
		if (WDOG_FROM_RC) begin
			wd.tick = WDOG_ENABLE && rc_osc_tick;
		end else begin
			wd.tick = WDOG_ENABLE && (div4_q == 2'(iwh_pkg::INSTR_CLK_DIV - 1))
				&& (st_q == iwh_pkg::IWH_RUN);
		end
		wd.clear = !ext_rst_pin || kick_clr || halting;
		wd.ratio = wdog_prescale_reg_q[2:0];
	end

	iwh_wdog_cnt u_wdog (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.wd      (wd)
	);

	// Wake sources; flags pending before halt are excluded
	always_comb begin
		wake_ev = (st_q == iwh_pkg::IWH_HALTED) && (port_wake
			|| (irq_control_reg_q[iwh_pkg::BIT_UPND] && !pnd_usb_at_halt_q)
			|| (irq_control_reg_q[iwh_pkg::BIT_TPND]
				&& !pnd_tmr_at_halt_q));
	end

	// Watchdog wake from halt also waits out the start-up delay
	iwh_wake_timer u_wake (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.start   (wake_ev || (st_q == iwh_pkg::IWH_HALTED && wd.expire)),
		.done    (wake_done)
	);

	// Halt sequencer
	always_ff @(posedge ref_clk) begin
		if (!reset_n || !ext_rst_pin) begin
			st_q <= iwh_pkg::IWH_RUN;
		end else begin
			unique case (st_q)
				iwh_pkg::IWH_RUN: begin
					if (halting) begin
						st_q <= iwh_pkg::IWH_HALTED;
					end
				end
				iwh_pkg::IWH_HALTED: begin
					if (wd.expire || wake_ev) begin
						st_q <= iwh_pkg::IWH_WAKING;
					end
				end
				iwh_pkg::IWH_WAKING: begin
					if (wake_done) begin
						st_q <= iwh_pkg::IWH_RUN;
					end
				end
				default: st_q <= iwh_pkg::IWH_RUN;
			endcase
		end
	end

	// Snapshot of pending flags at halt entry
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pnd_usb_at_halt_q <= 1'b0;
			pnd_tmr_at_halt_q <= 1'b0;
		end else if (halting) begin
			pnd_usb_at_halt_q <= irq_control_reg_q[iwh_pkg::BIT_UPND];
			pnd_tmr_at_halt_q <= irq_control_reg_q[iwh_pkg::BIT_TPND];
		end
	end

	// Status flags; writes to status leave them alone
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			wdog_expired_flag_q <= 1'b0;
			powerdown_flag_q    <= 1'b0;
		end else begin
			if (kick_clr) begin
				wdog_expired_flag_q <= 1'b0;
				powerdown_flag_q    <= 1'b0;
			end
			if (halting) begin
				powerdown_flag_q    <= 1'b1;
				wdog_expired_flag_q <= 1'b0;
			end
			if (wd.expire) begin
				wdog_expired_flag_q <= 1'b1;
			end
		end
	end

	// Reset and oscillator outputs
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			chip_reset   <= 1'b0;
			warm_reset   <= 1'b0;
			sys_osc_stop <= 1'b0;
			core_stall   <= 1'b0;
		end else begin
			chip_reset   <= wd.expire && (st_q != iwh_pkg::IWH_HALTED);
			warm_reset   <= wd.expire && (st_q == iwh_pkg::IWH_HALTED);
			sys_osc_stop <= halting || (st_q == iwh_pkg::IWH_HALTED
				&& !wake_ev && !wd.expire);
			core_stall   <= halting || (st_q != iwh_pkg::IWH_RUN
				&& !(st_q == iwh_pkg::IWH_WAKING && wake_done));
		end
	end

	// Register read port
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			mem_rdata <= 8'h00;
		end else if (mem_rd) begin
			unique case (mem_addr)
				iwh_pkg::OFS_IRQ_CONTROL:
					mem_rdata <= irq_control_reg_q & iwh_pkg::IRQ_CTRL_IMPL;
				iwh_pkg::OFS_WDOG_PRESCALE: mem_rdata <= wdog_prescale_reg_q;
				iwh_pkg::OFS_USB_FIFO_REQ:  mem_rdata <= usb_fifo_request_reg_q;
				iwh_pkg::OFS_USB_EVENT:     mem_rdata <= usb_event_ctrl_reg_q;
				iwh_pkg::OFS_SYS_CLK_CFG:   mem_rdata <= sys_clock_cfg_reg_q;
				iwh_pkg::OFS_STATUS: begin
					mem_rdata <= 8'h00;
					mem_rdata[iwh_pkg::BIT_PDF] <= powerdown_flag_q;
					mem_rdata[iwh_pkg::BIT_TO]  <= wdog_expired_flag_q;
				end
				default: mem_rdata <= 8'h00;
			endcase
		end
	end
endmodule

/* iwh_ctrl_asserts.sv */
// Port checker for the interrupt, watchdog and halt controller
// Assumes default options and a bind onto every iwh_ctrl
`timescale 1ns/100ps
module iwh_ctrl_asserts (
	input wire logic       ref_clk,
	input wire logic       reset_n,
	input wire logic       ext_rst_pin,
	input wire logic       mem_rd,
	input wire logic [7:0] mem_addr,
	input wire logic [7:0] mem_rdata,
	input wire logic       phase_two_pulse,
	input wire logic       stack_full,
	input wire logic       wdog_kick,
	input wire logic       halt_exec,
	input wire logic       rc_osc_tick,
	input wire logic       irq_call,
	input wire logic [7:0] irq_vector,
	input wire logic       sys_osc_stop,
	input wire logic       core_stall,
	input wire logic       chip_reset,
	input wire logic       warm_reset
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	logic [10:0] wake_q;
	logic [15:0] tick_q;
	// Cycles stalled with the oscillator running again
	always_ff @(posedge ref_clk) begin
		if (!reset_n || !core_stall || sys_osc_stop)
			wake_q <= 11'h000;
		else if (wake_q != 11'h7ff)
			wake_q <= wake_q + 11'h001;
	end
	// Watchdog ticks since the last clearing event
	always_ff @(posedge ref_clk) begin
		if (!reset_n || !ext_rst_pin || wdog_kick || halt_exec)
			tick_q <= 16'h0000;
		else if (chip_reset || warm_reset)
			tick_q <= 16'h0000;
		else if (rc_osc_tick && tick_q != 16'hffff)
			tick_q <= tick_q + 16'h0001;
	end
	property p_ctrl_gaps;
		mem_rd && mem_addr == iwh_pkg::OFS_IRQ_CONTROL
		|=> (mem_rdata & 8'ha4) == 8'h00;
	endproperty
	a_ctrl_gaps: assert property (p_ctrl_gaps)
		else $error("irq control reserved bit reads one");
	property p_call_gate;
		irq_call |-> $past(phase_two_pulse && !stack_full);
	endproperty
	a_call_gate: assert property (p_call_gate)
		else $error("call without service pulse or with full stack");
	property p_vec;
		irq_call |-> irq_vector == iwh_pkg::VEC_USB
			|| irq_vector == iwh_pkg::VEC_TIMER;
	endproperty
	a_vec: assert property (p_vec)
		else $error("call to an unknown vector");
	property p_vec_hold;
		!irq_call |-> $stable(irq_vector);
	endproperty
	a_vec_hold: assert property (p_vec_hold)
		else $error("vector moved without a call");
	property p_halt;
		halt_exec && !core_stall && ext_rst_pin
		|=> core_stall && sys_osc_stop;
	endproperty
	a_halt: assert property (p_halt)
		else $error("halt did not stop oscillator and core");
	property p_stall_quiet;
		core_stall && $past(core_stall) |-> !irq_call;
	endproperty
	a_stall_quiet: assert property (p_stall_quiet)
		else $error("call while core stalled");
	property p_wake;
		$fell(core_stall) && !$past(sys_osc_stop)
		|-> wake_q inside {[11'h3fc:11'h404]};
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake delay length wrong");
	property p_warm;
		warm_reset |-> $past(sys_osc_stop) && !chip_reset;
	endproperty
	a_warm: assert property (p_warm)
		else $error("warm reset outside halt");
	property p_chip;
		chip_reset |-> !$past(sys_osc_stop);
	endproperty
	a_chip: assert property (p_chip)
		else $error("chip reset during halt");
	property p_tick;
		chip_reset || warm_reset
		|-> tick_q inside {[16'h00fe:16'h8004]};
	endproperty
	a_tick: assert property (p_tick)
		else $error("watchdog expired too early or late");
endmodule
bind iwh_ctrl iwh_ctrl_asserts u_chk (
	.ref_clk         (ref_clk),
	.reset_n         (reset_n),
	.ext_rst_pin     (ext_rst_pin),
	.mem_rd          (mem_rd),
	.mem_addr        (mem_addr),
	.mem_rdata       (mem_rdata),
	.phase_two_pulse (phase_two_pulse),
	.stack_full      (stack_full),
	.wdog_kick       (wdog_kick),
	.halt_exec       (halt_exec),
	.rc_osc_tick     (rc_osc_tick),
	.irq_call        (irq_call),
	.irq_vector      (irq_vector),
	.sys_osc_stop    (sys_osc_stop),
	.core_stall      (core_stall),
	.chip_reset      (chip_reset),
	.warm_reset      (warm_reset)
);

/* irq_watchdog_halt_ctrl_test.sv */
// Self-checking bench for the interrupt, watchdog and halt controller
// Assumes iwh_ctrl with default options and the bound checker
`timescale 1ns/100ps
module irq_watchdog_halt_ctrl_test;
	logic       ref_clk = 1'b0;
	logic       reset_n;
	logic       ext_rst_pin;
	logic       mem_wr;
	logic       mem_rd;
	logic [7:0] mem_addr;
	logic [7:0] mem_wdata;
	logic [7:0] mem_rdata;
	logic       phase_two_pulse;
	logic       stack_full;
	logic       interrupt_exit;
	logic       subroutine_exit;
	logic       wdog_kick;
	logic       wdog_kick_first;
	logic       wdog_kick_second;
	logic       halt_exec;
	logic       rc_osc_tick = 1'b0;
	logic       timer_overflow;
	logic [1:0] host_fifo_access;
	logic       usb_suspend;
	logic       usb_resume;
	logic       usb_bus_reset;
	logic       port_wake;
	logic       irq_call;
	logic [7:0] irq_vector;
	logic       sys_osc_stop;
	logic       core_stall;
	logic       chip_reset;
	logic       warm_reset;
	int         miscompares;
	int         compares;
	int         seed;
	int         n;
	int         k;
	logic [7:0] d;

	iwh_ctrl uut (.*);

	// Clock and free running watchdog oscillator, one tick per two cycles
	always #4 ref_clk = ~ref_clk;
	always @(negedge ref_clk) rc_osc_tick <= ~rc_osc_tick;

	// Comparison, verdict and bus helpers
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cyc(input int c);
		repeat (c) @(negedge ref_clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		mem_addr = a;
		mem_wdata = v;
		pulse(mem_wr);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		mem_addr = a;
		pulse(mem_rd);
		v = mem_rdata;
		cyc(1); // Idle edge keeps back to back strobes apart
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		check(v, exp);
	endtask
	// Bounded wait for a level, cycles used in c
	task automatic wait_lv(ref logic s, input logic lv, input int lim,
		output int c);
		c = 0;
		while (s !== lv && c < lim) begin
			cyc(1);
			c++;
		end
		if (c >= lim) begin
			miscompares++;
			give_verdict();
		end
	endtask
	// Service pulse, then the call and vector seen one cycle later
	task automatic serve(input logic call, input logic [7:0] vec);
		pulse(phase_two_pulse);
		check({7'h00, irq_call}, {7'h00, call});
		if (call)
			check(irq_vector, vec);
	endtask

	// Main sequence
	initial begin
		seed = 19759;
		{mem_wr, mem_rd, mem_addr, mem_wdata} = '0;
		{phase_two_pulse, stack_full, interrupt_exit, subroutine_exit} = '0;
		{wdog_kick, wdog_kick_first, wdog_kick_second, halt_exec} = '0;
		{timer_overflow, host_fifo_access, usb_suspend, usb_resume} = '0;
		{usb_bus_reset, port_wake, miscompares, compares} = '0;
		ext_rst_pin = 1'b1;
		reset_n = 1'b0;
		cyc(8);
		reset_n = 1'b1;
		rdchk(iwh_pkg::OFS_IRQ_CONTROL, 8'h00);
		rdchk(iwh_pkg::OFS_WDOG_PRESCALE, 8'h87);
		rdchk(iwh_pkg::OFS_SYS_CLK_CFG, 8'h00);
		wr(iwh_pkg::OFS_SYS_CLK_CFG, 8'h01);
		rdchk(iwh_pkg::OFS_SYS_CLK_CFG, 8'h01);
		repeat (6) begin
			d = 8'($random(seed)) & 8'haf;
			wr(iwh_pkg::OFS_IRQ_CONTROL, d);
			rdchk(iwh_pkg::OFS_IRQ_CONTROL, d & 8'h0b);
		end
		$display("registers done");
		// Timer request held off by a full stack, then served
		wr(iwh_pkg::OFS_IRQ_CONTROL, 8'h09);
		pulse(timer_overflow);
		rdchk(iwh_pkg::OFS_IRQ_CONTROL, 8'h49);
		stack_full = 1'b1;
		serve(1'b0, 8'h00);
		stack_full = 1'b0;
		rdchk(iwh_pkg::OFS_IRQ_CONTROL, 8'h49);
		serve(1'b1, iwh_pkg::VEC_TIMER);
		rdchk(iwh_pkg::OFS_IRQ_CONTROL, 8'h08);
		// USB beats timer when both arrive together
		wr(iwh_pkg::OFS_IRQ_CONTROL, 8'h0b);
		host_fifo_access = 2'b10;
		pulse(timer_overflow);
		host_fifo_access = 2'b00;
		rdchk(iwh_pkg::OFS_USB_FIFO_REQ, 8'h02);
		serve(1'b1, iwh_pkg::VEC_USB);
		rdchk(iwh_pkg::OFS_IRQ_CONTROL, 8'h4a);
		pulse(interrupt_exit);
		rdchk(iwh_pkg::OFS_IRQ_CONTROL, 8'h4b);
		serve(1'b1, iwh_pkg::VEC_TIMER);
		pulse(subroutine_exit);
		rdchk(iwh_pkg::OFS_IRQ_CONTROL, 8'h0a);
		wr(iwh_pkg::OFS_USB_FIFO_REQ, 8'h00);
		rdchk(iwh_pkg::OFS_USB_FIFO_REQ, 8'h00);
		pulse(timer_overflow);
		serve(1'b0, 8'h00);
		rdchk(iwh_pkg::OFS_IRQ_CONTROL, 8'h4a);
		// Suspend, resume and bus reset events
		for (n = 0; n < 3; n++) begin
			wr(iwh_pkg::OFS_IRQ_CONTROL, 8'h00);
			{usb_suspend, usb_resume, usb_bus_reset} = 3'h4 >> n;
			cyc(1);
			{usb_suspend, usb_resume, usb_bus_reset} = 3'h0;
			rd(iwh_pkg::OFS_USB_EVENT, d);
			k = n == 0 ? iwh_pkg::BIT_SUSPEND
				: n == 1 ? iwh_pkg::BIT_RESUME : iwh_pkg::BIT_BUS_RST;
			check({7'h00, d[k]}, 8'h01);
			rdchk(iwh_pkg::OFS_IRQ_CONTROL, 8'h10);
		end
		$display("interrupts done");
		// Ratio field and measured timeouts
		for (n = 0; n < 8; n++) begin
			wr(iwh_pkg::OFS_WDOG_PRESCALE, 8'h80 | 8'(n));
			rdchk(iwh_pkg::OFS_WDOG_PRESCALE, 8'h80 | 8'(n));
		end
		for (n = 0; n < 3; n++) begin
			wr(iwh_pkg::OFS_WDOG_PRESCALE, 8'h80 | 8'(n));
			pulse(wdog_kick);
			wait_lv(chip_reset, 1'b1, 3000, k);
			check(8'(k > (512 << n) - 6 && k < (512 << n) + 6), 8'h01);
			rd(iwh_pkg::OFS_STATUS, d);
			check({7'h00, d[iwh_pkg::BIT_TO]}, 8'h01);
		end
		wr(iwh_pkg::OFS_WDOG_PRESCALE, 8'h80);
		pulse(wdog_kick);
		rd(iwh_pkg::OFS_STATUS, d);
		check({7'h00, d[iwh_pkg::BIT_TO]}, 8'h00);
		cyc(300 + {$random(seed)} % 150);
		ext_rst_pin = 1'b0;
		cyc(1);
		ext_rst_pin = 1'b1;
		wait_lv(chip_reset, 1'b1, 700, k);
		check(8'(k > 500), 8'h01);
		$display("watchdog done");
		// Halt, pin wake and the start-up delay
		wr(iwh_pkg::OFS_WDOG_PRESCALE, 8'h87);
		pulse(wdog_kick);
		pulse(halt_exec);
		check({6'h00, core_stall, sys_osc_stop}, 8'h03);
		rd(iwh_pkg::OFS_STATUS, d);
		check(d & 8'h30, 8'h10);
		pulse(port_wake);
		wait_lv(core_stall, 1'b0, 1200, k);
		check(8'(k > 1016 && k < 1030), 8'h01);
		// A flag pending before halt does not wake
		wr(iwh_pkg::OFS_IRQ_CONTROL, 8'h00);
		pulse(timer_overflow);
		pulse(halt_exec);
		cyc(50);
		check({7'h00, core_stall}, 8'h01);
		pulse(port_wake);
		wait_lv(core_stall, 1'b0, 1200, k);
		check(8'(k > 1016 && k < 1030), 8'h01);
		// Enabled timer request wakes and is then served
		wr(iwh_pkg::OFS_IRQ_CONTROL, 8'h09);
		pulse(halt_exec);
		pulse(timer_overflow);
		wait_lv(core_stall, 1'b0, 1200, k);
		check(8'(k > 1016 && k < 1030), 8'h01);
		serve(1'b1, iwh_pkg::VEC_TIMER);
		// Watchdog expiry while halted
		wr(iwh_pkg::OFS_WDOG_PRESCALE, 8'h80);
		pulse(halt_exec);
		wait_lv(warm_reset, 1'b1, 700, k);
		check(8'(k > 500), 8'h01);
		rd(iwh_pkg::OFS_STATUS, d);
		check(d & 8'h30, 8'h30);
		wait_lv(core_stall, 1'b0, 1200, k);
		check(8'(k > 1016 && k < 1030), 8'h01);
		$display("halt done");
		give_verdict();
	end
endmodule
